// file: inc/slc_pkg.sv
/*
  Constants, encodings and the behaviour list for the stack limit and
  effective address check block. Assumes a 16-bit data space, a 24-bit
  program counter and a core that sequences one operand access at a time.
*/
// Behaviour
// (RQ1) Register fifteen is upward-growing stack pointer.
// (RQ2) Push writes then increments; pop decrements first.
// (RQ3) Call push clears counter's top bit.
// (RQ4) Exception push joins status byte to counter.
// (RQ5) Limit bit zero forced zero; reset undefined.
// (RQ6) Stack-pointer addresses compared with limit; code compares only pushes and stack-pointer post-increment accesses.
// (RQ7) Push at limit allowed; next push traps.
// (RQ8) Stack address below boundary traps underflow.
// (RQ9) No stack read right after limit write.
// (RQ10) Boot secure RAM only from boot flash.
// (RQ11) Secure RAM only from secure flash.
// (RQ12) File register direct reaches near data only.
// (RQ13) File ops use register zero; result selectable.
// (RQ14) Move direct reaches the whole data space.
// (RQ15) Three-operand: register base, flexible second source.
// (RQ16) Operand modes: direct, indirect, post, pre, literal.
// (RQ17) Post-modify after use; pre-modify before address.
// (RQ18) Overflow and underflow share one trap request.
package slc_pkg;

  // ==========================================================
  // Widths and fixed values.
  localparam int          DATA_W          = 16;
  localparam int          PC_W            = 24;
  localparam int          NUM_DEFAULT_WORKING_REG        = 16;
  localparam logic [3:0]  SP_INDEX        = 4'hf;
  localparam logic [3:0]  DEFAULT_WORKING_REG_ZERO_INDEX = 4'h0;
  localparam logic [15:0] UNDERFLOW_BOUND = 16'h0800;
  localparam logic [15:0] NEAR_LIMIT      = 16'h2000;
  localparam int          NEAR_ADDR_W     = 13;
  localparam logic [15:0] WORD_STEP       = 16'h0002;
  localparam logic [15:0] SP_RESET        = 16'h0800;
  localparam logic [15:0] DEFAULT_WORKING_REG_RESET      = 16'h0000;
  localparam logic [15:0] LIMIT_RESET     = 16'h0000;

  // ==========================================================
  // Operand addressing modes.
  typedef enum logic [2:0] {
    slc_mode_reg_direct,
    slc_mode_indirect,
    slc_mode_post_inc,
    slc_mode_post_dec,
    slc_mode_pre_inc,
    slc_mode_pre_dec,
    slc_mode_literal,
    slc_mode_file_reg
  } slc_mode_t;

  // Stack operations.
  typedef enum logic [2:0] {
    slc_stk_none,
    slc_stk_push,
    slc_stk_pop,
    slc_stk_call,
    slc_stk_exception
  } slc_stk_t;

  // Engine states.
  typedef enum logic [1:0] {
    slc_st_idle,
    slc_st_pc_high
  } slc_state_t;

endpackage

// file: verilog/slc_seg_check.sv
/*
  One secure RAM segment window check.
  Assumes the window bounds are stable while the enable is high.
*/
`timescale 1ns/1ps
module slc_seg_check
  import slc_pkg::*;
(
  // Segment setup
  input  wire logic              enable,
  input  wire logic [DATA_W-1:0] seg_start,
  input  wire logic [DATA_W-1:0] seg_end,
  input  wire logic              from_owner,
  // Access
  input  wire logic              access,
  input  wire logic [DATA_W-1:0] addr,
  output logic                   violation
);

  // ==========================================================
  // Window compare.
  logic in_window;
  assign in_window = (addr >= seg_start) && (addr <= seg_end);
  assign violation = enable && access && in_window && !from_owner;

endmodule

// file: verilog/slc_stack_ea.sv
/*
  Stack pointer, stack limit and effective address generation with
  stack error and secure RAM checks. Assumes the core presents one
  request per cycle while ready is high and uses the trap outputs in the
  same cycle as the address.
*/
`timescale 1ns/1ps
module slc_stack_ea
  import slc_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset,
  // Stack requests
  input  wire slc_stk_t          stk_op,
  input  wire logic [PC_W-1:0]   pc_value,
  input  wire logic [7:0]        status_low_byte,
  input  wire logic [DATA_W-1:0] push_data,
  output logic                   stk_ready,
  // Operand requests
  input  wire logic              opr_valid,
  input  wire slc_mode_t         opr_mode,
  input  wire logic [3:0]        opr_reg,
  input  wire logic [3:0]        base_operand_reg,
  input  wire logic [9:0]        opr_literal,
  input  wire logic              opr_long_literal,
  input  wire logic [NEAR_ADDR_W-1:0] file_addr,
  input  wire logic [DATA_W-1:0] move_addr,
  input  wire logic              move_instruction,
  input  wire logic              multiply_instruction,
  input  wire logic              dest_is_default_working_reg,
  input  wire logic [DATA_W-1:0] pre_offset,
  // Register writes from the core
  input  wire logic              default_working_reg_we,
  input  wire logic [3:0]        default_working_reg_sel,
  input  wire logic [DATA_W-1:0] default_working_reg_wdata,
  input  wire logic              limit_we,
  input  wire logic [DATA_W-1:0] limit_wdata,
  // Secure RAM setup
  input  wire logic              boot_secure_ram_en,
  input  wire logic [DATA_W-1:0] boot_secure_ram_start,
  input  wire logic [DATA_W-1:0] boot_secure_ram_end,
  input  wire logic              exec_in_boot_flash,
  input  wire logic              secure_segment_ram_en,
  input  wire logic [DATA_W-1:0] secure_segment_ram_start,
  input  wire logic [DATA_W-1:0] secure_segment_ram_end,
  input  wire logic              exec_in_secure_flash,
  // Memory side
  output logic                   mem_valid,
  output logic                   mem_write,
  output logic [DATA_W-1:0]      mem_addr,
  output logic [DATA_W-1:0]      mem_wdata,
  // Operand results
  output logic [DATA_W-1:0]      base_value,
  output logic [DATA_W-1:0]      literal_value,
  output logic                   operand_is_literal,
  output logic [3:0]             result_reg,
  output logic                   result_pair,
  output logic [DATA_W-1:0]      stack_pointer,
  output logic [DATA_W-1:0]      stack_limit,
  // Traps
  output logic                   stack_error_trap,
  output logic                   secure_ram_trap
);

  // ==========================================================
  // Register file, limit and state.
  logic [DATA_W-1:0] default_working_reg [NUM_DEFAULT_WORKING_REG];
  logic [DATA_W-1:0] stack_limit_reg;
  logic [DATA_W-1:0] stack_pointer_reg;
  logic [DATA_W-1:0] pc_high_hold;
  slc_state_t        state;

  // (RQ1) Register fifteen pointer.
  assign stack_pointer_reg = default_working_reg[SP_INDEX];
  assign stack_pointer     = stack_pointer_reg;
  assign stack_limit       = stack_limit_reg;
  assign stk_ready         = (state == slc_st_idle);

  // ==========================================================
  // Stack address generation.
  logic              stk_push;
  logic              stk_pop;
  logic              stk_pc;
  logic [DATA_W-1:0] stk_addr;
  logic [DATA_W-1:0] stk_wdata;
  logic [DATA_W-1:0] pc_low;
  logic [DATA_W-1:0] pc_high_call;
  logic [DATA_W-1:0] pc_high_exc;

  assign pc_low       = pc_value[DATA_W-1:0];
  // (RQ3) Call top cleared.
  assign pc_high_call = {8'h00, 1'b0, pc_value[PC_W-2:DATA_W]};
  // (RQ4) Status byte joined.
  assign pc_high_exc  = {status_low_byte, pc_value[PC_W-1:DATA_W]};

  always_comb begin
    stk_push  = 1'b0;
    stk_pop   = 1'b0;
    stk_pc    = 1'b0;
    stk_wdata = push_data;
    if (state == slc_st_pc_high) begin
      stk_push  = 1'b1;
      stk_wdata = pc_high_hold;
    end else begin
      case (stk_op)
        slc_stk_push: begin
          stk_push = 1'b1;
        end
        slc_stk_pop: begin
          stk_pop = 1'b1;
        end
        slc_stk_call, slc_stk_exception: begin
          stk_push  = 1'b1;
          stk_pc    = 1'b1;
          stk_wdata = pc_low;
        end
        default: begin
          stk_push = 1'b0;
        end
      endcase
    end
  end

  // (RQ2) Pop predecrements address.
  assign stk_addr = stk_pop ? (stack_pointer_reg - WORD_STEP) : stack_pointer_reg;

  // ==========================================================
  // Operand address generation.
  logic              opr_ind;
  logic              opr_uses_sp;
  logic [DATA_W-1:0] ptr;
  logic [DATA_W-1:0] opr_addr;
  logic [DATA_W-1:0] next_ptr;
  logic              ptr_update;

  assign ptr = default_working_reg[opr_reg];

  // (RQ16) Operand modes.
  always_comb begin
    opr_ind    = 1'b1;
    opr_addr   = ptr;
    next_ptr   = ptr;
    ptr_update = 1'b0;
    case (opr_mode)
      slc_mode_indirect: begin
        opr_addr = ptr;
      end
      // (RQ17) Post modify after.
      slc_mode_post_inc: begin
        next_ptr   = ptr + WORD_STEP;
        ptr_update = 1'b1;
      end
      slc_mode_post_dec: begin
        next_ptr   = ptr - WORD_STEP;
        ptr_update = 1'b1;
      end
      // (RQ17) Pre modify before.
      slc_mode_pre_inc, slc_mode_pre_dec: begin
        next_ptr   = ptr + pre_offset;
        opr_addr   = next_ptr;
        ptr_update = 1'b1;
      end
      slc_mode_file_reg: begin
        // (RQ14) Move reaches everything.
        if (move_instruction) begin
          opr_addr = move_addr;
        // (RQ12) Near space only.
        end else begin
          opr_addr = {{(DATA_W-NEAR_ADDR_W){1'b0}}, file_addr};
        end
      end
      default: begin
        opr_ind = 1'b0;
      end
    endcase
  end

  assign opr_uses_sp = opr_valid && opr_ind && (opr_mode != slc_mode_file_reg)
                       && (opr_reg == SP_INDEX);

  // ==========================================================
  // Stack error checks.
  logic              any_stk;
  logic [DATA_W-1:0] chk_addr;
  logic              chk_push;
  logic              over;
  logic              under;

  assign any_stk  = stk_push || stk_pop;
  assign chk_addr = any_stk ? stk_addr : opr_addr;
  assign chk_push = stk_push || (opr_uses_sp && (opr_mode == slc_mode_post_inc));
  // (RQ6) Compare with limit.
  // (RQ7) Equal push allowed.
  assign over  = (any_stk || opr_uses_sp) && chk_push && (chk_addr > stack_limit_reg);
  // (RQ8) Underflow boundary check.
  assign under = (any_stk || opr_uses_sp) && (chk_addr < UNDERFLOW_BOUND);
  // (RQ18) Common trap request.
  assign stack_error_trap = over || under;

  // ==========================================================
  // Secure RAM checks.
  logic acc_valid;
  logic boot_bad;
  logic sec_bad;

  assign acc_valid = any_stk || (opr_valid && opr_ind);

  // (RQ10) Boot segment owner.
  slc_seg_check u_boot_seg (
    .enable     (boot_secure_ram_en),
    .seg_start  (boot_secure_ram_start),
    .seg_end    (boot_secure_ram_end),
    .from_owner (exec_in_boot_flash),
    .access     (acc_valid),
    .addr       (chk_addr),
    .violation  (boot_bad)
  );

  // (RQ11) Secure segment owner.
  slc_seg_check u_sec_seg (
    .enable     (secure_segment_ram_en),
    .seg_start  (secure_segment_ram_start),
    .seg_end    (secure_segment_ram_end),
    .from_owner (exec_in_secure_flash),
    .access     (acc_valid),
    .addr       (chk_addr),
    .violation  (sec_bad)
  );

  assign secure_ram_trap = boot_bad || sec_bad;

  // ==========================================================
  // Memory request, blocked on any trap.
  assign mem_valid = acc_valid && !stack_error_trap && !secure_ram_trap;
  assign mem_write = stk_push || (!any_stk && !dest_is_default_working_reg);
  assign mem_addr  = chk_addr;
  assign mem_wdata = stk_wdata;

  // ==========================================================
  // Operand results.
  // (RQ15) Base is register direct.
  assign base_value         = default_working_reg[base_operand_reg];
  assign operand_is_literal = opr_valid && (opr_mode == slc_mode_literal);
  assign literal_value      = opr_long_literal ? {6'h00, opr_literal} : {11'h000, opr_literal[4:0]};
  // (RQ13) Default working register.
  assign result_reg  = (opr_mode == slc_mode_file_reg && !multiply_instruction) ? DEFAULT_WORKING_REG_ZERO_INDEX : opr_reg;
  assign result_pair = multiply_instruction;

  // ==========================================================
  // Call and exception sequence.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state        <= slc_st_idle;
      pc_high_hold <= DEFAULT_WORKING_REG_RESET;
    end else begin
      case (state)
        slc_st_idle: begin
          if (stk_pc && !stack_error_trap && !secure_ram_trap) begin
            state        <= slc_st_pc_high;
            pc_high_hold <= (stk_op == slc_stk_exception) ? pc_high_exc : pc_high_call;
          end
        end
        slc_st_pc_high: begin
          state <= slc_st_idle;
        end
        default: begin
          state <= slc_st_idle;
        end
      endcase
    end
  end

  // ==========================================================
  // Limit register.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      stack_limit_reg <= LIMIT_RESET;
    end else if (limit_we) begin
      // (RQ5) Bit zero forced.
      stack_limit_reg <= {limit_wdata[DATA_W-1:1], 1'b0};
    end
  end

  // ==========================================================
  // Working registers.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NUM_DEFAULT_WORKING_REG; i++) begin
        default_working_reg[i] <= (i == int'(SP_INDEX)) ? SP_RESET : DEFAULT_WORKING_REG_RESET;
      end
    end else begin
      if (default_working_reg_we) begin
        default_working_reg[default_working_reg_sel] <= (default_working_reg_sel == SP_INDEX) ? {default_working_reg_wdata[DATA_W-1:1], 1'b0} : default_working_reg_wdata;
      end
      if (opr_valid && ptr_update && !stack_error_trap && !secure_ram_trap && !any_stk) begin
        default_working_reg[opr_reg] <= next_ptr;
      end
      // (RQ2) Push then increment.
      if (stk_push && !stack_error_trap && !secure_ram_trap) begin
        default_working_reg[SP_INDEX] <= stack_pointer_reg + WORD_STEP;
      end else if (stk_pop && !stack_error_trap && !secure_ram_trap) begin
        default_working_reg[SP_INDEX] <= stk_addr;
      end
    end
  end

endmodule

// file: verif/slc_stack_ea_asserts.sv
/*
  Port checks for the stack and operand address block.
  Assumes one core clock and an asynchronous active high reset.
*/
`timescale 1ns/1ps
module slc_stack_ea_chk
  import slc_pkg::*;
(
  // Watched ports
  input wire logic              ref_clk,
  input wire logic              reset,
  input wire slc_stk_t          stk_op,
  input wire logic [7:0]        status_low_byte,
  input wire logic              default_working_reg_we,
  input wire logic              stk_ready,
  input wire logic              mem_valid,
  input wire logic              mem_write,
  input wire logic [DATA_W-1:0] mem_addr,
  input wire logic [DATA_W-1:0] mem_wdata,
  input wire logic [DATA_W-1:0] stack_pointer,
  input wire logic [DATA_W-1:0] stack_limit,
  input wire logic              stack_error_trap,
  input wire logic              secure_ram_trap
);
  // ==========================================
  // Properties.
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_trap_no_access: assert property (stack_error_trap |-> !mem_valid)
    else $error("stack trap did not block access");
  a_secure_no_access: assert property (secure_ram_trap |-> !mem_valid)
    else $error("secure trap did not block access");
  a_limit_aligned: assert property (stack_limit[0] == 1'b0)
    else $error("limit bit zero set");
  a_sp_aligned: assert property (stack_pointer[0] == 1'b0)
    else $error("stack pointer odd");
  a_push_limit: assert property (stk_op == slc_stk_push && stk_ready && stack_pointer >= UNDERFLOW_BOUND
    |-> stack_error_trap == (stack_pointer > stack_limit)) else $error("push limit check wrong");
  a_pop_under: assert property (stk_op == slc_stk_pop && stk_ready && stack_pointer <= UNDERFLOW_BOUND
    && stack_pointer >= 16'h0002 |-> stack_error_trap) else $error("underflow not trapped");
  a_pop_addr: assert property (stk_op == slc_stk_pop && stk_ready && !stack_error_trap
    && !secure_ram_trap |-> mem_valid && !mem_write && mem_addr == stack_pointer - 16'h0002)
    else $error("pop address wrong");
  a_push_step: assert property (stk_op == slc_stk_push && stk_ready && !stack_error_trap
    && !secure_ram_trap && !default_working_reg_we |=> stack_pointer == $past(stack_pointer) + 16'h0002)
    else $error("push did not advance pointer");
  a_call_high: assert property (stk_op == slc_stk_call && stk_ready && !stack_error_trap
    && !secure_ram_trap |=> !stk_ready && mem_wdata[15:7] == 9'h000) else $error("call high word wrong");
  a_exc_high: assert property (stk_op == slc_stk_exception && stk_ready && !stack_error_trap
    && !secure_ram_trap |=> mem_wdata[15:8] == $past(status_low_byte)) else $error("exception word wrong");
  a_call_refused: assert property (stk_op == slc_stk_call && stk_ready && (stack_error_trap
    || secure_ram_trap) |=> stk_ready) else $error("refused call still pushed high word");
endmodule

bind slc_stack_ea slc_stack_ea_chk chk_u (.ref_clk, .reset, .stk_op, .status_low_byte, .default_working_reg_we,
  .stk_ready, .mem_valid, .mem_write, .mem_addr, .mem_wdata, .stack_pointer, .stack_limit,
  .stack_error_trap, .secure_ram_trap);

// file: verif/slc_core_model.sv
/*
  Core side model: data memory for stack words and trap counter.
  Assumes writes land on the rising clock edge.
*/
`timescale 1ns/1ps
module slc_core_model
  import slc_pkg::*;
(
  // Clock and reset
  input wire logic              ref_clk,
  input wire logic              reset,
  // Memory and traps
  input wire logic              mem_valid,
  input wire logic              mem_write,
  input wire logic [DATA_W-1:0] mem_addr,
  input wire logic [DATA_W-1:0] mem_wdata,
  input wire logic              stack_error_trap,
  output logic [7:0]            trap_count
);
  // ==========================================
  // Storage.
  logic [DATA_W-1:0] ram [0:32767];
  always_ff @(posedge ref_clk) begin
    if (mem_valid && mem_write) begin
      ram[mem_addr[15:1]] <= mem_wdata;
    end
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      trap_count <= 8'h00;
    end else if (stack_error_trap) begin
      trap_count <= trap_count + 8'h01;
    end
  end
endmodule

// file: verif/testbench.sv
/*
  Directed bench for the stack and operand address block.
  Assumes zero latency answers and pointer updates one edge later.
*/
`timescale 1ns/1ps
module testbench;
  import slc_pkg::*;
  // ==========================================
  // Signals.
  logic ref_clk = 1'b0, reset = 1'b1, opr_valid = 1'b0, opr_long_literal = 1'b0, default_working_reg_we = 1'b0;
  logic limit_we = 1'b0, move_instruction = 1'b0, multiply_instruction = 1'b0, dest_is_default_working_reg = 1'b0;
  logic boot_secure_ram_en = 1'b1, exec_in_boot_flash = 1'b0;
  logic secure_segment_ram_en = 1'b1, exec_in_secure_flash = 1'b0;
  slc_stk_t stk_op = slc_stk_none;
  slc_mode_t opr_mode = slc_mode_reg_direct;
  logic [PC_W-1:0] pc_value = 24'h000000;
  logic [7:0] status_low_byte = 8'h00;
  logic [3:0] opr_reg = 4'h0, base_operand_reg = 4'h0, default_working_reg_sel = 4'h0;
  logic [9:0] opr_literal = 10'h000;
  logic [NEAR_ADDR_W-1:0] file_addr = 13'h0000;
  logic [DATA_W-1:0] push_data = 16'h0000, move_addr = 16'h0000, pre_offset = 16'h0000;
  logic [DATA_W-1:0] default_working_reg_wdata = 16'h0000, limit_wdata = 16'h0000;
  logic [DATA_W-1:0] boot_secure_ram_start = 16'h1000, boot_secure_ram_end = 16'h10fe;
  logic [DATA_W-1:0] secure_segment_ram_start = 16'h1100, secure_segment_ram_end = 16'h11fe;
  logic stk_ready, mem_valid, mem_write, operand_is_literal, result_pair, stack_error_trap, secure_ram_trap;
  logic [DATA_W-1:0] mem_addr, mem_wdata, base_value, literal_value, stack_pointer, stack_limit;
  logic [3:0] result_reg;
  logic [7:0] trap_count;
  int n_fail = 0;
  int cmp_count = 0;

  always #5 ref_clk = ~ref_clk;

  slc_stack_ea dut_u (.ref_clk, .reset, .stk_op, .pc_value, .status_low_byte, .push_data, .stk_ready,
    .opr_valid, .opr_mode, .opr_reg, .base_operand_reg, .opr_literal, .opr_long_literal, .file_addr,
    .move_addr, .move_instruction, .multiply_instruction, .dest_is_default_working_reg, .pre_offset, .default_working_reg_we, .default_working_reg_sel,
    .default_working_reg_wdata, .limit_we, .limit_wdata, .boot_secure_ram_en, .boot_secure_ram_start, .boot_secure_ram_end,
    .exec_in_boot_flash, .secure_segment_ram_en, .secure_segment_ram_start, .secure_segment_ram_end,
    .exec_in_secure_flash, .mem_valid, .mem_write, .mem_addr, .mem_wdata, .base_value, .literal_value,
    .operand_is_literal, .result_reg, .result_pair, .stack_pointer, .stack_limit, .stack_error_trap,
    .secure_ram_trap);
  slc_core_model core_u (.ref_clk, .reset, .mem_valid, .mem_write, .mem_addr, .mem_wdata,
    .stack_error_trap, .trap_count);

  // ==========================================
  // Tasks.
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic req(input slc_stk_t op, input logic ov, input logic we, input logic lwe);
    @(negedge ref_clk);
    stk_op = op;
    opr_valid = ov;
    default_working_reg_we = we;
    limit_we = lwe;
  endtask
  task automatic setw(input logic [3:0] sel, input logic [15:0] v);
    req(slc_stk_none, 1'b0, 1'b1, 1'b0);
    default_working_reg_sel = sel;
    default_working_reg_wdata = v;
  endtask
  task automatic setlim(input logic [15:0] v);
    req(slc_stk_none, 1'b0, 1'b0, 1'b1);
    limit_wdata = v;
    req(slc_stk_none, 1'b0, 1'b0, 1'b0);
    req(slc_stk_none, 1'b0, 1'b0, 1'b0);
  endtask
  task automatic stk(input slc_stk_t op, input logic [15:0] addr, input logic trap);
    req(op, 1'b0, 1'b0, 1'b0);
    #1;
    chk("stack addr", addr, mem_addr);
    chk("stack trap", 16'(trap), 16'(stack_error_trap));
    chk("access", 16'(!trap), 16'(mem_valid));
  endtask
  task automatic t_push_pop();
    chk("sp reset", 16'h0800, stack_pointer);
    setlim(16'h0807);
    chk("limit", 16'h0806, stack_limit);
    for (int i = 0; i < 5; i++) begin
      stk(slc_stk_push, 16'h0800 + 16'(2 * i), i == 4);
    end
    for (int i = 0; i < 5; i++) begin
      stk(slc_stk_pop, 16'h0806 - 16'(2 * i), i == 4);
    end
    req(slc_stk_none, 1'b0, 1'b0, 1'b0);
    chk("sp", 16'h0800, stack_pointer);
    $display("done push pop");
  endtask
  task automatic t_call();
    setlim(16'hfffe);
    for (int i = 0; i < 2; i++) begin
      req(i == 0 ? slc_stk_call : slc_stk_exception, 1'b0, 1'b0, 1'b0);
      pc_value = 24'habcdef;
      status_low_byte = 8'h5a;
      #1;
      chk("low word", 16'hcdef, mem_wdata);
      @(negedge ref_clk);
      #1;
      chk("ready", 16'h0000, 16'(stk_ready));
      chk("high addr", 16'h0802 + 16'(4 * i), mem_addr);
      chk("high word", i == 0 ? 16'h002b : 16'h5aab, mem_wdata);
    end
    req(slc_stk_none, 1'b0, 1'b0, 1'b0);
    chk("sp", 16'h0808, stack_pointer);
    $display("done call");
  endtask
  task automatic t_secure();
    for (int i = 0; i < 4; i++) begin
      if (i % 2 == 0) begin
        setw(SP_INDEX, i < 2 ? 16'h1000 : 16'h1100);
      end
      req(slc_stk_push, 1'b0, 1'b0, 1'b0);
      exec_in_boot_flash = (i == 1);
      exec_in_secure_flash = (i == 3);
      #1;
      chk("secure trap", 16'(i % 2 == 0), 16'(secure_ram_trap));
    end
    req(slc_stk_call, 1'b0, 1'b0, 1'b0);
    exec_in_secure_flash = 1'b0;
    #1;
    chk("call refused", 16'h0001, 16'(secure_ram_trap));
    req(slc_stk_none, 1'b0, 1'b0, 1'b0);
    #1;
    chk("no high word", 16'h0001, 16'(stk_ready));
    chk("sp kept", 16'h1102, stack_pointer);
    $display("done secure");
  endtask
  task automatic t_operand();
    setw(4'h1, 16'h2000);
    setw(4'h3, 16'h1234);
    req(slc_stk_none, 1'b1, 1'b0, 1'b0);
    opr_mode = slc_mode_file_reg;
    file_addr = 13'h1ffe;
    dest_is_default_working_reg = 1'b1;
    #1;
    chk("near addr", 16'h1ffe, mem_addr);
    chk("dest reg", 16'(DEFAULT_WORKING_REG_ZERO_INDEX), 16'(result_reg));
    chk("dest write", 16'h0000, 16'(mem_write));
    req(slc_stk_none, 1'b1, 1'b0, 1'b0);
    move_instruction = 1'b1;
    move_addr = 16'hf000;
    #1;
    chk("move addr", 16'hf000, mem_addr);
    req(slc_stk_none, 1'b1, 1'b0, 1'b0);
    move_instruction = 1'b0;
    opr_mode = slc_mode_post_inc;
    opr_reg = 4'h1;
    #1;
    chk("post addr", 16'h2000, mem_addr);
    req(slc_stk_none, 1'b1, 1'b0, 1'b0);
    opr_mode = slc_mode_indirect;
    #1;
    chk("after post", 16'h2002, mem_addr);
    req(slc_stk_none, 1'b1, 1'b0, 1'b0);
    opr_mode = slc_mode_pre_dec;
    pre_offset = 16'hfffe;
    #1;
    chk("pre addr", 16'h2000, mem_addr);
    for (int i = 0; i < 2; i++) begin
      req(slc_stk_none, 1'b1, 1'b0, 1'b0);
      opr_mode = slc_mode_literal;
      opr_literal = 10'h3ff;
      opr_long_literal = (i == 0);
      base_operand_reg = 4'h3;
      #1;
      chk("literal", i == 0 ? 16'h03ff : 16'h001f, literal_value);
      chk("base", 16'h1234, base_value);
      chk("literal flag", 16'h0001, 16'(operand_is_literal));
    end
    req(slc_stk_none, 1'b1, 1'b0, 1'b0);
    opr_mode = slc_mode_file_reg;
    multiply_instruction = 1'b1;
    #1;
    chk("mul dest", 16'h0001, 16'(result_reg));
    chk("mul pair", 16'h0001, 16'(result_pair));
    req(slc_stk_none, 1'b0, 1'b0, 1'b0);
    chk("trap count", 16'h0002, 16'(trap_count));
    $display("done operand");
  endtask

  initial begin
    #100000;
    n_fail++;
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    reset = 1'b0;
    t_push_pop();
    t_call();
    t_secure();
    t_operand();
    end_of_test();
  end
endmodule
